// >>> logic/iwg_guard.sv
// Purpose: Write guard, check-byte verification and fault error counter.
// Assumes: State, watchdog and fault event inputs are on clk; pins are not.
// Notes:   Frames are slave address, register address, data, check byte.
// Summary of operation
// - Check frames only when check enable set.
// - Compute check byte after each frame.
// - Bad check drops write, sets fault flag.
// - Fault flag clears only on written one.
// - CRC-8 polynomial 0x11D, preset 0xFF.
// - Buck on: bit one, complement zero, pin high.
// - Accept setting only when exactly complemented.
// - Critical settings writable only in setup state.
// - First good refresh locks counter/watchdog settings.
// - Limit codes give maxima 1, 2, 6, 12.
// - Four-bit count, zero after power-on reset.
// - Clear pair one/zero zeroes the count.
// - Refresh at refresh maximum decrements count.
// - Any enabled assigned fault increments the count, up to its maximum.
// - Voltage faults count if enabled and routed.
// - Enabled error inputs count each valid fault.
// - Enabled fault collection inputs count faults.
// - Error input faults count in normal only.
// - Watchdog power-good toggle increments count.
// - Routed voltage events assert power-good outputs.
`timescale 1ns/10ps
module iwg_guard #(
    parameter int NSRC = 6
) (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst_n,
    // Link
    input  wire logic            link_clk,
    input  wire logic            link_sel,
    input  wire logic            link_sda,
    // Configuration and state
    input  wire logic            crc_enable,
    input  wire logic            setup_state,
    input  wire logic            normal_state,
    input  wire logic            watchdog_enabled,
    // Watchdog events
    input  wire logic            first_good_refresh_event,
    input  wire logic            refresh_at_max_event,
    input  wire logic            watchdog_pgood_toggle,
    // Pins
    input  wire logic [1:0]      buck_enable_pin,
    // Voltage fault sources: bucks first, then monitors
    input  wire logic [NSRC-1:0] over_voltage_fault,
    input  wire logic [NSRC-1:0] under_voltage_fault,
    input  wire logic [NSRC-1:0] ov_to_pg_a,
    input  wire logic [NSRC-1:0] ov_to_pg_b,
    input  wire logic [NSRC-1:0] uv_to_pg_a,
    input  wire logic [NSRC-1:0] uv_to_pg_b,
    input  wire logic [NSRC-1:0] source_count_enable,
    // Error and fault collection inputs
    input  wire logic [1:0]      error_monitor_input,
    input  wire logic [1:0]      error_input_count_enable,
    input  wire logic [1:0]      fault_collection_input,
    input  wire logic            fault_collection_count_enable,
    // Outputs
    output logic      [1:0]      buck_output_enable,
    output logic      [1:0]      power_good_output,
    output logic                 crc_fault_flag,
    output logic      [3:0]      fault_count_value,
    output logic                 settings_locked,
    output logic                 fault_collection_bistable_select,
    output logic                 fault_collection_a_polarity,
    output logic                 fault_collection_b_polarity,
    output logic                 fault_collection_pair_polarity,
    output logic      [1:0]      fault_count_maximum,
    output logic      [1:0]      watchdog_error_maximum,
    output logic      [1:0]      watchdog_refresh_maximum,
    output logic      [1:0]      watchdog_failure_reaction
);
    // ------------------------------------------------------------
    // Link receiver and frame crossing
    // ------------------------------------------------------------
    iwg_frame_if frm ();

    iwg_link_rx u_rx (
        .link_clk   (link_clk),
        .rst_n      (rst_n),
        .link_sel   (link_sel),
        .link_sda   (link_sda),
        .crc_enable (crc_enable),
        .frm        (frm.src)
    );

    logic       tgl_m_reg;
    logic       tgl_s_reg;
    logic       tgl_d_reg;
    logic       frame_pulse;
    logic [1:0] pin_m_reg;
    logic [1:0] pin_s_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tgl_m_reg <= 1'b0;
            tgl_s_reg <= 1'b0;
            tgl_d_reg <= 1'b0;
            pin_m_reg <= 2'b00;
            pin_s_reg <= 2'b00;
        end else begin
            tgl_m_reg <= frm.done_tgl;
            tgl_s_reg <= tgl_m_reg;
            tgl_d_reg <= tgl_s_reg;
            pin_m_reg <= buck_enable_pin;
            pin_s_reg <= pin_m_reg;
        end
    end

    assign frame_pulse = tgl_s_reg ^ tgl_d_reg;

    // ------------------------------------------------------------
    // Check byte
    // ------------------------------------------------------------
    logic [23:0] hdr;
    logic [7:0]  crc_calc;
    logic        crc_ok;
    logic        wr;
    logic        crc_bad;

    // With checking off the frame is three bytes, so it sits lower.
    assign hdr = crc_enable ? frm.bytes[31:8] : frm.bytes[23:0];

    iwg_crc8 #(
        .NBYTES (3)
    ) u_crc (
        .data (hdr),
        .crc  (crc_calc)
    );

    assign crc_ok  = (crc_calc == frm.bytes[7:0]);
    assign wr      = frame_pulse && (!crc_enable || crc_ok);
    assign crc_bad = frame_pulse && crc_enable && !crc_ok;

    // ------------------------------------------------------------
    // Protected registers
    // ------------------------------------------------------------
    logic [7:0] cfga_reg;
    logic [7:0] cfga_n_reg;
    logic [7:0] cfgb_reg;
    logic [7:0] cfgb_n_reg;
    logic       clr_reg;
    logic       clr_n_reg;
    logic       lock_reg;
    logic       wr_a_ok;
    logic       wr_b_ok;
    logic [7:0] addr;
    logic [7:0] wdata;

    assign addr    = hdr[15:8];
    assign wdata   = hdr[7:0];
    assign wr_a_ok = wr && setup_state;
    assign wr_b_ok = wr && setup_state && !lock_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_reg <= 1'b0;
        end else if (first_good_refresh_event && setup_state && watchdog_enabled) begin
            lock_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfga_reg   <= iwg_pkg::CFGA_RST;
            cfga_n_reg <= ~iwg_pkg::CFGA_RST;
        end else if (wr_a_ok) begin
            if (addr == iwg_pkg::REG_CFGA) begin
                cfga_reg <= wdata;
            end
            if (addr == iwg_pkg::REG_CFGA_N) begin
                cfga_n_reg <= wdata;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfgb_reg   <= iwg_pkg::CFGB_RST;
            cfgb_n_reg <= ~iwg_pkg::CFGB_RST;
            clr_reg    <= 1'b0;
            clr_n_reg  <= 1'b1;
        end else if (wr_b_ok) begin
            if (addr == iwg_pkg::REG_CFGB) begin
                cfgb_reg <= wdata;
            end
            if (addr == iwg_pkg::REG_CFGB_N) begin
                cfgb_n_reg <= wdata;
            end
            if (addr == iwg_pkg::REG_CLR) begin
                clr_reg <= wdata[0];
            end
            if (addr == iwg_pkg::REG_CLR_N) begin
                clr_n_reg <= wdata[0];
            end
        end
    end

    // ------------------------------------------------------------
    // Accepted values follow only exact complement pairs
    // ------------------------------------------------------------
    logic [7:0] cfga_acc_reg;
    logic [7:0] cfgb_acc_reg;
    logic       cfga_pair;
    logic       cfgb_pair;

    assign cfga_pair = &(cfga_reg ^ cfga_n_reg);
    assign cfgb_pair = &(cfgb_reg ^ cfgb_n_reg);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfga_acc_reg <= iwg_pkg::CFGA_RST;
            cfgb_acc_reg <= iwg_pkg::CFGB_RST;
        end else begin
            if (cfga_pair) begin
                cfga_acc_reg <= cfga_reg;
            end
            if (cfgb_pair) begin
                cfgb_acc_reg <= cfgb_reg;
            end
        end
    end

    assign fault_collection_bistable_select = cfga_acc_reg[iwg_pkg::A_BISTABLE];
    assign fault_collection_a_polarity      = cfga_acc_reg[iwg_pkg::A_POL_A];
    assign fault_collection_b_polarity      = cfga_acc_reg[iwg_pkg::A_POL_B];
    assign fault_collection_pair_polarity   = cfga_acc_reg[iwg_pkg::A_POL_PAIR];
    assign fault_count_maximum       = cfgb_acc_reg[iwg_pkg::B_LIMIT_LO +: 2];
    assign watchdog_error_maximum    = cfgb_acc_reg[iwg_pkg::B_ERR_LO +: 2];
    assign watchdog_refresh_maximum  = cfgb_acc_reg[iwg_pkg::B_RFR_LO +: 2];
    assign watchdog_failure_reaction = cfgb_acc_reg[iwg_pkg::B_FAIL_LO +: 2];
    assign settings_locked           = lock_reg;

    // ------------------------------------------------------------
    // Buck enables and check fault flag
    // ------------------------------------------------------------
    logic [1:0] buck_enable_bit;
    logic [1:0] buck_enable_complement;
    logic [1:0] buck_out_reg;
    logic       crc_flag_reg;
    logic       flag_clear;

    assign buck_enable_bit        = cfga_reg[iwg_pkg::A_BUCK_LO +: 2];
    assign buck_enable_complement = cfga_n_reg[iwg_pkg::A_BUCK_LO +: 2];
    assign flag_clear = wr && addr == iwg_pkg::REG_STAT && wdata[iwg_pkg::STAT_CRC];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            buck_out_reg <= 2'b00;
        end else begin
            buck_out_reg <= buck_enable_bit & ~buck_enable_complement & pin_s_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_flag_reg <= 1'b0;
        end else if (crc_bad) begin
            crc_flag_reg <= 1'b1;
        end else if (flag_clear) begin
            crc_flag_reg <= 1'b0;
        end
    end

    assign buck_output_enable = buck_out_reg;
    assign crc_fault_flag     = crc_flag_reg;

    // ------------------------------------------------------------
    // Fault sources and power-good assertion
    // ------------------------------------------------------------
    logic [NSRC-1:0] src_hit;
    logic [NSRC-1:0] pg_a_hit;
    logic [NSRC-1:0] pg_b_hit;
    logic [1:0]      pg_reg;
    logic            inc;

    for (genvar i = 0; i < NSRC; i++) begin : g_src
        assign pg_a_hit[i] = (over_voltage_fault[i] & ov_to_pg_a[i])
                           | (under_voltage_fault[i] & uv_to_pg_a[i]);
        assign pg_b_hit[i] = (over_voltage_fault[i] & ov_to_pg_b[i])
                           | (under_voltage_fault[i] & uv_to_pg_b[i]);
        assign src_hit[i]  = source_count_enable[i] & (pg_a_hit[i] | pg_b_hit[i]);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pg_reg <= 2'b00;
        end else begin
            pg_reg <= {|pg_b_hit, |pg_a_hit};
        end
    end

    assign power_good_output = pg_reg;

    // Coincident events count once; the sources are rare against clk.
    assign inc = (|src_hit)
               | (normal_state & |(error_monitor_input & error_input_count_enable))
               | (fault_collection_count_enable & |fault_collection_input)
               | watchdog_pgood_toggle;

    // ------------------------------------------------------------
    // Fault error counter
    // ------------------------------------------------------------
    logic [3:0] cnt_reg;
    logic [3:0] cnt_max;
    logic [1:0] lim_d_reg;
    logic       clr_ok;
    logic       clr_d_reg;

    always_comb begin
        unique case (fault_count_maximum)
            2'b00: cnt_max = iwg_pkg::LIM_00;
            2'b01: cnt_max = iwg_pkg::LIM_01;
            2'b10: cnt_max = iwg_pkg::LIM_10;
            2'b11: cnt_max = iwg_pkg::LIM_11;
        endcase
    end

    assign clr_ok = clr_reg & ~clr_n_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clr_d_reg <= 1'b0;
            lim_d_reg <= iwg_pkg::CFGB_RST[1:0];
        end else begin
            clr_d_reg <= clr_ok;
            lim_d_reg <= fault_count_maximum;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= iwg_pkg::CNT_RST;
        end else if ((clr_ok && !clr_d_reg) || lim_d_reg != fault_count_maximum) begin
            cnt_reg <= iwg_pkg::CNT_RST;
        end else if (inc && !refresh_at_max_event) begin
            if (cnt_reg < cnt_max) begin
                cnt_reg <= cnt_reg + 4'h1;
            end
        end else if (refresh_at_max_event && !inc && cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
        end
    end

    assign fault_count_value = cnt_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    localparam logic [3:0] LIM_CAP = iwg_pkg::LIM_11;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence bad_frame_s;
        crc_bad && !flag_clear;
    endsequence

    sequence flag_up_s;
        crc_flag_reg [*2];
    endsequence

    crc_drop_a: assert property (crc_bad |=> $stable(cfga_reg) && $stable(cfgb_reg))
        else $error("write applied despite bad check byte");
    crc_flag_a: assert property (bad_frame_s |=> flag_up_s)
        else $error("check fault flag not set and held");
    flag_hold_a: assert property (crc_flag_reg && !flag_clear |=> crc_flag_reg)
        else $error("check fault flag dropped without clear");
    buck_gate_a: assert property (!pin_s_reg[0] |=> !buck_output_enable[0])
        else $error("buck enabled while pin low");
    pair_accept_a: assert property (!cfgb_pair |=> $stable(cfgb_acc_reg))
        else $error("unmatched pair changed accepted value");
    normal_lock_a: assert property (!setup_state |=> $stable(cfga_reg))
        else $error("critical setting changed outside setup");
    wd_lock_a: assert property (lock_reg |=> $stable(cfgb_reg) && $stable(clr_reg))
        else $error("locked setting changed");
    cnt_limit_a: assert property (fault_count_value <= LIM_CAP)
        else $error("count above largest maximum");
    cnt_clear_a: assert property (clr_ok && !clr_d_reg |=> fault_count_value == 4'h0)
        else $error("clear pair did not zero count");
    cnt_dec_a: assert property (refresh_at_max_event && !inc && cnt_reg != 4'h0
        && !clr_ok && lim_d_reg == fault_count_maximum |=> cnt_reg == $past(cnt_reg) - 4'h1)
        else $error("refresh at maximum did not decrement");
    err_setup_a: assert property (!normal_state && error_monitor_input != 2'b00 && src_hit == '0
        && !fault_collection_input[0] && !fault_collection_input[1] && !watchdog_pgood_toggle
        && !refresh_at_max_event && !clr_ok && lim_d_reg == fault_count_maximum
        |=> $stable(cnt_reg))
        else $error("error input counted outside normal state");
endmodule

// >>> logic/iwg_pkg.sv
// Purpose: Shared constants for the write guard and fault counter.
// Assumes: Register addresses are carried in the second byte of a link frame.
// Notes:   All offsets, fields, reset values and counts live here.
package iwg_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CFGA   = 8'h10;
    localparam logic [7:0] REG_CFGA_N = 8'h11;
    localparam logic [7:0] REG_CFGB   = 8'h12;
    localparam logic [7:0] REG_CFGB_N = 8'h13;
    localparam logic [7:0] REG_CLR    = 8'h14;
    localparam logic [7:0] REG_CLR_N  = 8'h15;
    localparam logic [7:0] REG_STAT   = 8'h20;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int A_BUCK_LO   = 0;
    localparam int A_BISTABLE  = 2;
    localparam int A_POL_A     = 3;
    localparam int A_POL_B     = 4;
    localparam int A_POL_PAIR  = 5;
    localparam int B_LIMIT_LO  = 0;
    localparam int B_ERR_LO    = 2;
    localparam int B_RFR_LO    = 4;
    localparam int B_FAIL_LO   = 6;
    localparam int STAT_CRC    = 0;

    // ------------------------------------------------------------
    // Reset values and CRC constants
    // ------------------------------------------------------------
    localparam logic [7:0] CFGA_RST   = 8'h00;
    localparam logic [7:0] CFGB_RST   = 8'h01;
    localparam logic [7:0] CRC_POLY   = 8'h1d;
    localparam logic [7:0] CRC_PRESET = 8'hff;
    localparam logic [3:0] CNT_RST    = 4'h0;

    // ------------------------------------------------------------
    // Fault counter maximum per limit code
    // ------------------------------------------------------------
    localparam logic [3:0] LIM_00 = 4'h1;
    localparam logic [3:0] LIM_01 = 4'h2;
    localparam logic [3:0] LIM_10 = 4'h6;
    localparam logic [3:0] LIM_11 = 4'hc;

    // Link frame sizes in bits, without and with the check byte.
    localparam logic [5:0] FRAME_BITS     = 6'h18;
    localparam logic [5:0] FRAME_BITS_CRC = 6'h20;

endpackage

// >>> logic/iwg_frame_if.sv
// Purpose: Carries a received frame from the link domain to the core.
// Assumes: Bytes stay stable until the next frame completes.
// Notes:   done_tgl flips once per complete frame.
`timescale 1ns/10ps
interface iwg_frame_if;
    logic [31:0] bytes;
    logic        done_tgl;
    modport src (output bytes, output done_tgl);
    modport dst (input bytes, input done_tgl);
endinterface

// >>> logic/iwg_crc8.sv
// Purpose: Combinational CRC-8 over a packed byte string, MSB first.
// Assumes: Most significant byte is processed first.
// Notes:   No final inversion is applied.
`timescale 1ns/10ps
module iwg_crc8 #(
    parameter int NBYTES = 3
) (
    // Data in
    input  wire logic [8*NBYTES-1:0] data,
    // Result
    output logic      [7:0]          crc
);
    always_comb begin
        logic [7:0] c;
        c = iwg_pkg::CRC_PRESET;
        for (int i = 8*NBYTES-1; i >= 0; i--) begin
            if (c[7] ^ data[i]) begin
                c = {c[6:0], 1'b0} ^ iwg_pkg::CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        crc = c;
    end
endmodule

// >>> logic/iwg_link_rx.sv
// Purpose: Shifts serial frame bits in on the link clock.
// Assumes: The link clock runs only while link_sel is high.
// Notes:   A low link_sel clears the bit count without a clock edge.
`timescale 1ns/10ps
module iwg_link_rx (
    // Link side
    input  wire logic link_clk,
    input  wire logic rst_n,
    input  wire logic link_sel,
    input  wire logic link_sda,
    // Configuration from the core clock domain
    input  wire logic crc_enable,
    // Frame towards the core
    iwg_frame_if.src  frm
);
    logic        frame_rst_n;
    logic        en_m_reg;
    logic        en_s_reg;
    logic [5:0]  bit_cnt_reg;
    logic [31:0] shift_reg;
    logic [31:0] bytes_reg;
    logic        tgl_reg;
    logic [5:0]  last_bit;

    // The frame's own select ends it, since no edge follows the last bit.
    assign frame_rst_n = rst_n & link_sel;
    assign last_bit    = (en_s_reg ? iwg_pkg::FRAME_BITS_CRC : iwg_pkg::FRAME_BITS) - 6'h01;

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_m_reg <= 1'b0;
            en_s_reg <= 1'b0;
        end else begin
            en_m_reg <= crc_enable;
            en_s_reg <= en_m_reg;
        end
    end

    always_ff @(posedge link_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            bit_cnt_reg <= 6'h00;
        end else if (bit_cnt_reg <= last_bit) begin
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
        end
    end

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= 32'h0000_0000;
            bytes_reg <= 32'h0000_0000;
            tgl_reg   <= 1'b0;
        end else if (link_sel && bit_cnt_reg <= last_bit) begin
            shift_reg <= {shift_reg[30:0], link_sda};
            if (bit_cnt_reg == last_bit) begin
                bytes_reg <= {shift_reg[30:0], link_sda};
                tgl_reg   <= ~tgl_reg;
            end
        end
    end

    assign frm.bytes    = bytes_reg;
    assign frm.done_tgl = tgl_reg;
endmodule

// >>> tb/iwg_host_model.sv
// Purpose: Host model that sends register write frames on the link.
// Assumes: Link clock runs at 160 ns and only while a frame is sent.
// Notes:   A bad frame flips one bit of the check byte.
`timescale 1ns/10ps
module iwg_host_model (
    // Link
    output logic link_clk,
    output logic link_sel,
    output logic link_sda
);
    initial begin
        link_clk = 1'h0;
        link_sel = 1'h0;
        link_sda = 1'h1;
    end
    // Check byte covers address, register and data, MSB first.
    task automatic send(input logic [7:0] ra, input logic [7:0] d, input logic bad);
        logic [31:0] f;
        logic [7:0]  c;
        f = {8'h5a, ra, d, 8'h00};
        c = 8'hff;
        for (int i = 31; i >= 8; i--) begin
            c = {c[6:0], 1'h0} ^ ((c[7] ^ f[i]) ? 8'h1d : 8'h00);
        end
        f[7:0] = c ^ {7'h00, bad};
        #3 link_sel = 1'h1;
        for (int i = 31; i >= 0; i--) begin
            link_sda = f[i];
            #80 link_clk = 1'h1;
            #80 link_clk = 1'h0;
        end
        link_sel = 1'h0;
        // Released data shows the inverse so a stale bit is never mistaken for data.
        link_sda = ~link_sda;
        #400;
    endtask
endmodule

// >>> tb/iwg_guard_tb.sv
// Purpose: Self-checking bench for the write guard and fault counter.
// Assumes: Check byte is enabled except for one step of the guard test.
// Notes:   Events are one-cycle pulses driven on the rising edge.
`timescale 1ns/10ps
module iwg_guard_tb;
    logic       clk;
    logic       rst_n;
    logic       link_clk;
    logic       link_sel;
    logic       link_sda;
    logic       setup_state;
    logic       normal_state;
    logic       watchdog_enabled;
    logic       fault_collection_count_enable;
    logic       crc_enable;
    logic [5:0] source_count_enable;
    logic [5:0] ov_to_pg_b;
    logic [1:0] buck_enable_pin;
    logic [5:0] ev;
    logic [1:0] buck_output_enable;
    logic [1:0] power_good_output;
    logic       crc_fault_flag;
    logic [3:0] fault_count_value;
    logic [1:0] fault_count_maximum;
    int         fails;
    int         comparisons;

    iwg_host_model iwg_host_model_inst (.link_clk, .link_sel, .link_sda);
    iwg_guard iwg_guard_inst (.clk, .rst_n, .link_clk, .link_sel, .link_sda, .crc_enable, .setup_state,
        .normal_state, .watchdog_enabled, .first_good_refresh_event(ev[0]), .refresh_at_max_event(ev[1]),
        .watchdog_pgood_toggle(ev[2]), .buck_enable_pin, .over_voltage_fault({5'h00, ev[3]}),
        .under_voltage_fault(6'h00), .ov_to_pg_a(6'h01), .ov_to_pg_b, .uv_to_pg_a(6'h00),
        .uv_to_pg_b(6'h00), .source_count_enable, .error_monitor_input({1'h0, ev[4]}),
        .error_input_count_enable(2'h1), .fault_collection_input({1'h0, ev[5]}), .fault_collection_count_enable,
        .buck_output_enable, .power_good_output, .crc_fault_flag, .fault_count_value, .settings_locked(),
        .fault_collection_bistable_select(), .fault_collection_a_polarity(), .fault_collection_b_polarity(),
        .fault_collection_pair_polarity(), .fault_count_maximum, .watchdog_error_maximum(),
        .watchdog_refresh_maximum(), .watchdog_failure_reaction());

    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] ra, input logic [7:0] d, input logic bad);
        iwg_host_model_inst.send(ra, d, bad);
        repeat (12) @(posedge clk);
    endtask

    task automatic pulse(input logic [5:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 6'h00;
        #1;
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_guard;
        chk(fault_count_value, 4'h0);
        chk(fault_count_maximum, 4'h1);
        wr(8'h10, 8'h03, 1'h0);
        wr(8'h11, 8'hfc, 1'h1);
        chk(crc_fault_flag, 4'h1);
        chk(buck_output_enable, 4'h0);
        wr(8'h11, 8'hfc, 1'h0);
        chk(buck_output_enable, 4'h3);
        wr(8'h20, 8'h00, 1'h0);
        chk(crc_fault_flag, 4'h1);
        wr(8'h20, 8'h01, 1'h0);
        chk(crc_fault_flag, 4'h0);
        buck_enable_pin <= 2'h2;
        setup_state <= 1'h0;
        wr(8'h10, 8'h00, 1'h0);
        wr(8'h11, 8'hff, 1'h0);
        chk(buck_output_enable, 4'h2);
        setup_state <= 1'h1;
        crc_enable <= 1'h0;
        wr(8'h11, 8'hfe, 1'h1);
        chk(crc_fault_flag, 4'h0);
        chk(buck_output_enable, 4'h0);
        crc_enable <= 1'h1;
        $display("test guard done");
    endtask

    task automatic t_count;
        pulse(6'h20);
        chk(fault_count_value, 4'h0);
        fault_collection_count_enable <= 1'h1;
        pulse(6'h20);
        chk(fault_count_value, 4'h1);
        pulse(6'h10);
        chk(fault_count_value, 4'h1);
        normal_state <= 1'h1;
        pulse(6'h10);
        chk(fault_count_value, 4'h2);
        pulse(6'h20);
        chk(fault_count_value, 4'h2);
        pulse(6'h02);
        chk(fault_count_value, 4'h1);
        pulse(6'h04);
        chk(fault_count_value, 4'h2);
        pulse(6'h02);
        pulse(6'h08);
        chk(power_good_output, 4'h1);
        chk(fault_count_value, 4'h2);
        source_count_enable <= 6'h00;
        ov_to_pg_b <= 6'h01;
        pulse(6'h02);
        pulse(6'h08);
        chk(power_good_output, 4'h3);
        chk(fault_count_value, 4'h1);
        wr(8'h14, 8'h01, 1'h0);
        wr(8'h15, 8'h00, 1'h0);
        chk(fault_count_value, 4'h0);
        normal_state <= 1'h0;
        watchdog_enabled <= 1'h1;
        pulse(6'h01);
        wr(8'h12, 8'h03, 1'h0);
        wr(8'h13, 8'hfc, 1'h0);
        chk(fault_count_maximum, 4'h1);
        $display("test count done");
    endtask

    initial begin
        rst_n = 1'h0;
        setup_state = 1'h1;
        normal_state = 1'h0;
        watchdog_enabled = 1'h0;
        fault_collection_count_enable = 1'h0;
        crc_enable = 1'h1;
        source_count_enable = 6'h01;
        ov_to_pg_b = 6'h00;
        buck_enable_pin = 2'h3;
        ev = 6'h00;
        fails = 0;
        comparisons = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'h1;
        repeat (2) @(posedge clk);
        t_guard;
        t_count;
        tally_and_finish;
    end

    initial begin
        #400000;
        fails++;
        tally_and_finish;
    end
endmodule
